// ---- logic/t2w_pkg.sv ----
// Purpose: Shared constants for the 8-bit timer wave and clock control.
// Assumes: Byte-wide register port at the timer's documented offsets.
// Notes:   The register offsets, field positions and byte reset value live here.
package t2w_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] T2W_OFF_CTRL_A  = 8'hB0;
  localparam logic [7:0] T2W_OFF_CTRL_B  = 8'hB1;
  localparam logic [7:0] T2W_OFF_COUNT   = 8'hB2;
  localparam logic [7:0] T2W_OFF_CMP_A   = 8'hB3;
  localparam logic [7:0] T2W_OFF_CMP_B   = 8'hB4;

  // ----------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] T2W_RST_BYTE    = 8'h00;
  localparam int         T2W_A_ACT_HI    = 7;
  localparam int         T2W_A_ACT_LO    = 6;
  localparam int         T2W_B_ACT_HI    = 5;
  localparam int         T2W_B_ACT_LO    = 4;
  localparam int         T2W_MODE_HI_A   = 1;
  localparam int         T2W_FORCE_A     = 7;
  localparam int         T2W_FORCE_B     = 6;
  localparam int         T2W_MODE_HI_B   = 3;
  localparam int         T2W_CS_HI       = 2;
  localparam logic [7:0] T2W_CTRL_A_MASK = 8'hF3;
  localparam logic [7:0] T2W_CTRL_B_MASK = 8'h0F;

  // ----------------------------------------------------------------------
  // Count limits and action codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] T2W_MAX         = 8'hFF;
  localparam logic [7:0] T2W_BOTTOM      = 8'h00;
  localparam logic [1:0] T2W_ACT_OFF     = 2'h0;
  localparam logic [1:0] T2W_ACT_TOGGLE  = 2'h1;
  localparam logic [1:0] T2W_ACT_CLEAR   = 2'h2;
  localparam logic [1:0] T2W_ACT_SET     = 2'h3;

  // ----------------------------------------------------------------------
  // Waveform mode codes and prescaler
  // ----------------------------------------------------------------------
  localparam logic [2:0] T2W_WM_NORMAL   = 3'h0;
  localparam logic [2:0] T2W_WM_PC_FF    = 3'h1;
  localparam logic [2:0] T2W_WM_CTC      = 3'h2;
  localparam logic [2:0] T2W_WM_FAST_FF  = 3'h3;
  localparam logic [2:0] T2W_WM_PC_A     = 3'h5;
  localparam logic [2:0] T2W_WM_FAST_A   = 3'h7;
  localparam logic [2:0] T2W_CS_STOP     = 3'h0;
  localparam logic [2:0] T2W_CS_DIRECT   = 3'h1;
  localparam int         T2W_PRE_W       = 10;

  typedef enum logic [1:0] {
    T2W_CL_NONPWM = 2'h0,
    T2W_CL_FAST   = 2'h1,
    T2W_CL_PHASE  = 2'h2
  } t2w_class_t;

endpackage

// ---- logic/t2w_prescaler.sv ----
// Purpose: Divides the selected timer source into the counting tick.
// Assumes: src_tick is a one-cycle pulse per source clock edge.
// Notes:   A stopped selection holds the divider at zero.
`timescale 1ns/1ps
`default_nettype none
module t2w_prescaler (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         nrst,
  // Source and selection
  input  wire logic                         src_tick,
  input  wire logic [2:0]                   clk_prescale_sel,
  // Counting tick
  output logic                              tick
);
  import t2w_pkg::*;

  logic [T2W_PRE_W-1:0] pre_reg;
  logic [T2W_PRE_W-1:0] pre_next;

  // ----------------------------------------------------------------------
  // Division mask per selection
  // ----------------------------------------------------------------------
  function automatic logic [T2W_PRE_W-1:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h2:    div_mask = 10'h007;
      3'h3:    div_mask = 10'h01F;
      3'h4:    div_mask = 10'h03F;
      3'h5:    div_mask = 10'h07F;
      3'h6:    div_mask = 10'h0FF;
      3'h7:    div_mask = 10'h3FF;
      default: div_mask = 10'h000;
    endcase
  endfunction

  always_comb begin
    pre_next = pre_reg;
    if (clk_prescale_sel == T2W_CS_STOP) begin
      pre_next = '0;
    end else if (src_tick) begin
      pre_next = pre_reg + 10'h001;
    end
  end

  // Stop, undivided, then /8 to /1024 per selection.
  assign tick = src_tick && (clk_prescale_sel != T2W_CS_STOP) &&
                ((pre_reg & div_mask(clk_prescale_sel)) ==
                 div_mask(clk_prescale_sel));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_next;
    end
  end

endmodule
`default_nettype wire

// ---- logic/t2w_wave_out.sv ----
// Purpose: One compare channel's waveform level and pin override.
// Assumes: Match and TOP events are one-cycle pulses qualified by the timer tick; force_strobe follows the register write.
// Notes:   Used for both channels with the same action tables.
`timescale 1ns/1ps
`default_nettype none
module t2w_wave_out (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         nrst,
  // Mode and action
  input  wire t2w_pkg::t2w_class_t          wave_class,
  input  wire logic [1:0]                   action,
  // Events
  input  wire logic                         match,
  input  wire logic                         force_strobe,
  input  wire logic                         at_top,
  input  wire logic                         at_wrap,
  input  wire logic                         cmp_is_top,
  input  wire logic                         dir_down,
  // Pin
  input  wire logic                         pin_dir,
  input  wire logic                         port_data,
  output logic                              pin_out,
  output logic                              pin_oe,
  output logic                              wave_level
);
  import t2w_pkg::*;

  logic wave_reg;
  logic wave_next;
  logic linked;

  // ----------------------------------------------------------------------
  // Waveform level
  // ----------------------------------------------------------------------
  always_comb begin
    wave_next = wave_reg;
    case (wave_class)
      T2W_CL_NONPWM: begin
        if (match || force_strobe) begin
          case (action)
            T2W_ACT_TOGGLE: wave_next = !wave_reg;
            T2W_ACT_CLEAR:  wave_next = 1'b0;
            T2W_ACT_SET:    wave_next = 1'b1;
            default:        wave_next = wave_reg;
          endcase
        end
      end
      T2W_CL_FAST: begin
        if (action[1]) begin
          if (at_wrap) begin
            wave_next = !action[0];
          end else if (match && !cmp_is_top) begin
            wave_next = action[0];
          end
        end
      end
      T2W_CL_PHASE: begin
        if (action[1]) begin
          if (cmp_is_top) begin
            if (at_top) begin
              wave_next = !action[0];
            end
          end else if (match) begin
            wave_next = dir_down ? !action[0] : action[0];
          end
        end
      end
      default: wave_next = wave_reg;
    endcase
  end

  // ----------------------------------------------------------------------
  // Pin override
  // ----------------------------------------------------------------------
  assign linked = (action != T2W_ACT_OFF) &&
                  !((wave_class != T2W_CL_NONPWM) &&
                    (action == T2W_ACT_TOGGLE));
  assign pin_out    = linked ? wave_reg : port_data;
  assign pin_oe     = pin_dir;
  assign wave_level = wave_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wave_reg <= 1'b0;
    end else begin
      wave_reg <= wave_next;
    end
  end

endmodule
`default_nettype wire

// ---- logic/t2w_timer.sv ----
// Purpose: 8-bit timer with two compare channels, mode decode and prescaler.
// Assumes: Byte register port in the clk domain; crystal clock is a pin.
// Notes:   Crystal edges pass a two-stage synchroniser before use.
`timescale 1ns/1ps
`default_nettype none
module t2w_timer (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         nrst,
  // Register port
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [7:0]                        reg_rdata,
  // Clock source
  input  wire logic                         clk_src_async,
  input  wire logic                         crystal_clk_pin,
  // Channel A pin
  input  wire logic                         chan_a_pin_dir,
  input  wire logic                         chan_a_port_data,
  output logic                              chan_a_wave_pin,
  output logic                              chan_a_wave_oe,
  // Channel B pin
  input  wire logic                         chan_b_pin_dir,
  input  wire logic                         chan_b_port_data,
  output logic                              chan_b_wave_pin,
  output logic                              chan_b_wave_oe,
  // Events
  output logic                              overflow_flag,
  output logic                              match_a_evt,
  output logic                              match_b_evt
);
  import t2w_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0] control_a_reg, control_a_next;
  logic [7:0] control_b_reg, control_b_next;
  logic [7:0] counter_value_reg, counter_value_next;
  logic [7:0] cmp_a_buf_reg, cmp_a_buf_next;
  logic [7:0] cmp_b_buf_reg, cmp_b_buf_next;
  logic [7:0] compare_value_a_reg, compare_value_a_next;
  logic [7:0] compare_value_b_reg, compare_value_b_next;
  logic       dir_down_reg, dir_down_next;
  logic       block_reg, block_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [2:0] xtal_sync_reg;
  logic [2:0] wave_mode_sel;
  logic [1:0] chan_a_output_action;
  logic [1:0] chan_b_output_action;
  logic [2:0] clk_prescale_sel;
  t2w_class_t wave_class;
  logic [7:0] top_val;
  logic       src_tick, tick;
  logic       wr_count, wr_ctrl_b;
  logic       force_match_a, force_match_b;
  logic       at_top, at_wrap, upd_cmp;
  logic       raw_match_a, raw_match_b;
  logic       ovf_next, ovf_reg, ma_reg, mb_reg;

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  assign chan_a_output_action = control_a_reg[T2W_A_ACT_HI:T2W_A_ACT_LO];
  assign chan_b_output_action = control_a_reg[T2W_B_ACT_HI:T2W_B_ACT_LO];
  assign wave_mode_sel    = {control_b_reg[T2W_MODE_HI_B],
                             control_a_reg[T2W_MODE_HI_A:0]};
  assign clk_prescale_sel = control_b_reg[T2W_CS_HI:0];

  function automatic t2w_class_t mode_class(input logic [2:0] wm);
    case (wm)
      T2W_WM_PC_FF, T2W_WM_PC_A:     mode_class = T2W_CL_PHASE;
      T2W_WM_FAST_FF, T2W_WM_FAST_A: mode_class = T2W_CL_FAST;
      default:                       mode_class = T2W_CL_NONPWM;
    endcase
  endfunction

  // TOP per mode; reserved modes count as normal.
  assign wave_class = mode_class(wave_mode_sel);
  assign top_val = ((wave_mode_sel == T2W_WM_CTC) ||
                    (wave_mode_sel == T2W_WM_PC_A) ||
                    (wave_mode_sel == T2W_WM_FAST_A)) ?
                   compare_value_a_reg : T2W_MAX;

  // ----------------------------------------------------------------------
  // Clock source
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xtal_sync_reg <= 3'h0;
    end else begin
      xtal_sync_reg <= {xtal_sync_reg[1:0], crystal_clk_pin};
    end
  end

  // I/O clock by default, crystal edges when selected.
  assign src_tick = clk_src_async ? (xtal_sync_reg[1] && !xtal_sync_reg[2])
                                  : 1'b1;

  t2w_prescaler u_pre (
    .clk              (clk),
    .nrst             (nrst),
    .src_tick         (src_tick),
    .clk_prescale_sel (clk_prescale_sel),
    .tick             (tick)
  );

  // ----------------------------------------------------------------------
  // Register writes and strobes
  // ----------------------------------------------------------------------
  assign wr_count  = reg_wr && (reg_addr == T2W_OFF_COUNT);
  assign wr_ctrl_b = reg_wr && (reg_addr == T2W_OFF_CTRL_B);
  assign force_match_a = wr_ctrl_b && reg_wdata[T2W_FORCE_A] &&
                         (wave_class == T2W_CL_NONPWM);
  assign force_match_b = wr_ctrl_b && reg_wdata[T2W_FORCE_B] &&
                         (wave_class == T2W_CL_NONPWM);

  // ----------------------------------------------------------------------
  // Counter sequence
  // ----------------------------------------------------------------------
  assign at_top  = tick && (counter_value_reg == top_val);
  assign at_wrap = at_top && (wave_class == T2W_CL_FAST);
  // Continuous equality, blocked on the tick after a counter write.
  assign raw_match_a = tick && !block_reg &&
                       (counter_value_reg == compare_value_a_reg);
  assign raw_match_b = tick && !block_reg &&
                       (counter_value_reg == compare_value_b_reg);

  always_comb begin
    counter_value_next = counter_value_reg;
    dir_down_next      = dir_down_reg;
    ovf_next           = 1'b0;
    block_next         = block_reg;
    if (tick) begin
      block_next = 1'b0;
      case (wave_class)
        T2W_CL_PHASE: begin
          if (!dir_down_reg) begin
            if (counter_value_reg == top_val) begin
              dir_down_next      = 1'b1;
              counter_value_next = counter_value_reg - 8'h01;
            end else begin
              counter_value_next = counter_value_reg + 8'h01;
            end
          end else if (counter_value_reg == T2W_BOTTOM) begin
            dir_down_next      = 1'b0;
            ovf_next           = 1'b1;
            counter_value_next = counter_value_reg + 8'h01;
          end else begin
            counter_value_next = counter_value_reg - 8'h01;
          end
        end
        T2W_CL_FAST: begin
          dir_down_next = 1'b0;
          ovf_next      = at_top;
          counter_value_next = at_top ? T2W_BOTTOM
                                      : counter_value_reg + 8'h01;
        end
        default: begin
          dir_down_next = 1'b0;
          ovf_next      = (counter_value_reg == T2W_MAX);
          // Only a real match clears in CTC, never a force.
          if ((wave_mode_sel == T2W_WM_CTC) && raw_match_a) begin
            counter_value_next = T2W_BOTTOM;
          end else begin
            counter_value_next = counter_value_reg + 8'h01;
          end
        end
      endcase
    end
    if (wr_count) begin
      counter_value_next = reg_wdata;
      block_next         = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Control and compare registers
  // ----------------------------------------------------------------------
  // Compare buffers load immediately in non-PWM modes, at TOP in PWM modes.
  assign upd_cmp = (wave_class == T2W_CL_NONPWM) || at_top;

  always_comb begin
    control_a_next = control_a_reg;
    control_b_next = control_b_reg;
    cmp_a_buf_next = cmp_a_buf_reg;
    cmp_b_buf_next = cmp_b_buf_reg;
    if (reg_wr) begin
      case (reg_addr)
        T2W_OFF_CTRL_A: control_a_next = reg_wdata & T2W_CTRL_A_MASK;
        T2W_OFF_CTRL_B: control_b_next = reg_wdata & T2W_CTRL_B_MASK;
        T2W_OFF_CMP_A:  cmp_a_buf_next = reg_wdata;
        T2W_OFF_CMP_B:  cmp_b_buf_next = reg_wdata;
        default:        control_a_next = control_a_reg;
      endcase
    end
    compare_value_a_next = upd_cmp ? cmp_a_buf_reg : compare_value_a_reg;
    compare_value_b_next = upd_cmp ? cmp_b_buf_reg : compare_value_b_reg;
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      case (reg_addr)
        T2W_OFF_CTRL_A: rdata_next = control_a_reg;
        T2W_OFF_CTRL_B: rdata_next = control_b_reg;
        T2W_OFF_COUNT:  rdata_next = counter_value_reg;
        T2W_OFF_CMP_A:  rdata_next = cmp_a_buf_reg;
        T2W_OFF_CMP_B:  rdata_next = cmp_b_buf_reg;
        default:        rdata_next = T2W_RST_BYTE;
      endcase
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      control_a_reg       <= T2W_RST_BYTE;
      control_b_reg       <= T2W_RST_BYTE;
      counter_value_reg   <= T2W_RST_BYTE;
      cmp_a_buf_reg       <= T2W_RST_BYTE;
      cmp_b_buf_reg       <= T2W_RST_BYTE;
      compare_value_a_reg <= T2W_RST_BYTE;
      compare_value_b_reg <= T2W_RST_BYTE;
      dir_down_reg        <= 1'b0;
      block_reg           <= 1'b0;
      rdata_reg           <= T2W_RST_BYTE;
      ovf_reg             <= 1'b0;
      ma_reg              <= 1'b0;
      mb_reg              <= 1'b0;
    end else begin
      control_a_reg       <= control_a_next;
      control_b_reg       <= control_b_next;
      counter_value_reg   <= counter_value_next;
      cmp_a_buf_reg       <= cmp_a_buf_next;
      cmp_b_buf_reg       <= cmp_b_buf_next;
      compare_value_a_reg <= compare_value_a_next;
      compare_value_b_reg <= compare_value_b_next;
      dir_down_reg        <= dir_down_next;
      block_reg           <= block_next;
      rdata_reg           <= rdata_next;
      ovf_reg             <= ovf_next;
      ma_reg              <= raw_match_a;
      mb_reg              <= raw_match_b;
    end
  end

  assign overflow_flag = ovf_reg;
  assign match_a_evt   = ma_reg;
  assign match_b_evt   = mb_reg;

  // ----------------------------------------------------------------------
  // Waveform channels
  // ----------------------------------------------------------------------
  t2w_wave_out u_wave_a (
    .clk          (clk),
    .nrst         (nrst),
    .wave_class   (wave_class),
    .action       (chan_a_output_action),
    .match        (raw_match_a),
    .force_strobe (force_match_a),
    .at_top       (at_top),
    .at_wrap      (at_wrap),
    .cmp_is_top   (compare_value_a_reg == top_val),
    .dir_down     (dir_down_reg),
    .pin_dir      (chan_a_pin_dir),
    .port_data    (chan_a_port_data),
    .pin_out      (chan_a_wave_pin),
    .pin_oe       (chan_a_wave_oe),
    .wave_level   ()
  );

  t2w_wave_out u_wave_b (
    .clk          (clk),
    .nrst         (nrst),
    .wave_class   (wave_class),
    .action       (chan_b_output_action),
    .match        (raw_match_b),
    .force_strobe (force_match_b),
    .at_top       (at_top),
    .at_wrap      (at_wrap),
    .cmp_is_top   (compare_value_b_reg == top_val),
    .dir_down     (dir_down_reg),
    .pin_dir      (chan_b_pin_dir),
    .port_data    (chan_b_port_data),
    .pin_out      (chan_b_wave_pin),
    .pin_oe       (chan_b_wave_oe),
    .wave_level   ()
  );

endmodule
`default_nettype wire

// ---- testbench/t2w_timer_props.sv ----
// Purpose: Port checks for the timer wave and clock control.
// Assumes: Control A is mirrored from writes on the register port.
// Notes:   Bound to the timer top.
`timescale 1ns/1ps
`default_nettype none
module t2w_timer_props (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       chan_a_pin_dir,
  input wire logic       chan_a_port_data,
  input wire logic       chan_a_wave_pin,
  input wire logic       chan_a_wave_oe,
  input wire logic       chan_b_pin_dir,
  input wire logic       chan_b_port_data,
  input wire logic       chan_b_wave_pin,
  input wire logic       chan_b_wave_oe,
  input wire logic       match_b_evt
);
  import t2w_pkg::*;
  logic [7:0] ctl_a_reg;
  logic [7:0] ctl_a_next;
  always_comb begin
    ctl_a_next = ctl_a_reg;
    if (reg_wr && reg_addr == T2W_OFF_CTRL_A) begin
      ctl_a_next = reg_wdata;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_a_reg <= 8'h00;
    end else begin
      ctl_a_reg <= ctl_a_next;
    end
  end
  // ----
  // Checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_oe_b_dir: assert property (chan_b_wave_oe == chan_b_pin_dir)
    else $error("channel B enable differs from direction");
  a_oe_a_dir: assert property (chan_a_wave_oe == chan_a_pin_dir)
    else $error("channel A enable differs from direction");
  a_port_b_pass: assert property (ctl_a_reg[5:4] == 2'h0 |->
    chan_b_wave_pin == chan_b_port_data) else $error("B port not passed");
  a_port_a_pass: assert property (ctl_a_reg[7:6] == 2'h0 |->
    chan_a_wave_pin == chan_a_port_data) else $error("A port not passed");
  a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'hB0 ||
    reg_addr > 8'hB4) |=> reg_rdata == 8'h00) else $error("unmapped data");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_ctrl_b_mask: assert property (reg_wr && reg_addr == 8'hB1 ##2
    reg_rd && reg_addr == 8'hB1 |=> reg_rdata ==
    ($past(reg_wdata, 3) & T2W_CTRL_B_MASK)) else $error("control B read");
  a_ctrl_a_mask: assert property (reg_wr && reg_addr == 8'hB0 ##2
    reg_rd && reg_addr == 8'hB0 |=> reg_rdata ==
    ($past(reg_wdata, 3) & T2W_CTRL_A_MASK)) else $error("control A read");
  c_match_b: cover property (match_b_evt);
  c_force: cover property (reg_wr && reg_addr == 8'hB1 && reg_wdata[7]);
  c_count_rd: cover property (reg_rd && reg_addr == 8'hB2);
endmodule
bind t2w_timer t2w_timer_props u_t2w_timer_props (.clk(clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_a_pin_dir(chan_a_pin_dir),
  .chan_a_port_data(chan_a_port_data), .chan_a_wave_pin(chan_a_wave_pin),
  .chan_a_wave_oe(chan_a_wave_oe), .chan_b_pin_dir(chan_b_pin_dir),
  .chan_b_port_data(chan_b_port_data), .chan_b_wave_pin(chan_b_wave_pin),
  .chan_b_wave_oe(chan_b_wave_oe), .match_b_evt(match_b_evt));
`default_nettype wire

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for the timer wave and clock control.
// Assumes: Timer counts on clk, or on the bench crystal in the last run.
// Notes:   Seeded random tops, compare values and pin inputs.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb;
  import t2w_pkg::*;
  logic       clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, ovf, ma, mb, p;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d, t;
  logic       adir = 0, adat = 0, bdir = 0, bdat = 0, apin, aoe, bpin, boe;
  logic       xsel = 0, xtal = 0;
  int         mismatches = 0, samples_checked = 0, seed = 32'h979f, n;
  int         dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  int         md [2] = '{3, 1};
  always #2.5 clk = ~clk;
  always #20 xtal = ~xtal;
  always @(negedge clk) {adir, adat, bdir, bdat} <= 4'($random(seed));
  t2w_timer u_t2w_timer (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .clk_src_async(xsel), .crystal_clk_pin(xtal),
    .chan_a_pin_dir(adir), .chan_a_port_data(adat), .chan_a_wave_pin(apin),
    .chan_a_wave_oe(aoe), .chan_b_pin_dir(bdir), .chan_b_port_data(bdat),
    .chan_b_wave_pin(bpin), .chan_b_wave_oe(boe), .overflow_flag(ovf),
    .match_a_evt(ma), .match_b_evt(mb));
  task automatic wrap_up();
    $display("mismatches %0d samples_checked %0d", mismatches,
      samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = v;
    reg_wr    = 1;
    @(negedge clk);
    reg_wr    = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1;
    @(negedge clk);
    reg_rd   = 0;
    d        = reg_rdata;
  endtask
  task automatic wt(input int b, input int w);
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > b) begin
        mismatches++;
        wrap_up();
      end
    end while ((w == 1 ? mb : (w == 2 ? ma : ovf)) !== 1'b1);
  endtask
  function automatic int per(input int m, input int tp, input int v);
    case (m)
      1:       return 510 * v;
      5:       return 2 * tp * v;
      2, 7:    return (tp + 1) * v;
      default: return 256 * v;
    endcase
  endfunction
  task automatic run(input int m, input int c, input int s);
    int k;
    t = 8'(1 + ($random(seed) & 3));
    k = per(m, t, dv[c] * s);
    wr(T2W_OFF_CTRL_B, 8'h00);
    wr(T2W_OFF_COUNT, 8'h00);
    wr(T2W_OFF_CTRL_A, 8'h00);
    wr(T2W_OFF_CMP_A, t);
    wr(T2W_OFF_CTRL_A, 8'(m & 3));
    wr(T2W_OFF_CTRL_B, 8'((m & 4) * 2 + c));
    wt(2 * k + 600, (m == 2) ? 2 : 0);
    wt(k + 8, (m == 2) ? 2 : 0);
    `CHK("period", k, n)
  endtask
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1;
    for (int a = 'hB0; a < 'hB6; a++) begin
      rd(8'(a));
      `CHK("reset", 8'h00, d)
    end
    wr(T2W_OFF_CTRL_B, 8'hC8);
    rd(T2W_OFF_CTRL_B);
    wr(T2W_OFF_CTRL_A, 8'hFF);
    rd(T2W_OFF_CTRL_A);
    t = 8'($random(seed));
    wr(T2W_OFF_CMP_B, t);
    rd(T2W_OFF_CMP_B);
    `CHK("compare", t, d)
    wr(T2W_OFF_COUNT, t);
    rd(T2W_OFF_COUNT);
    `CHK("count", t, d)
    wr(T2W_OFF_CTRL_B, 8'h00);
    wr(T2W_OFF_CTRL_A, 8'hF0);
    wr(T2W_OFF_CTRL_B, 8'hC0);
    `CHK("force", 3'b011, {mb, apin, bpin})
    wr(T2W_OFF_CTRL_A, 8'h50);
    wr(T2W_OFF_CTRL_B, 8'h40);
    `CHK("force_b", 2'b10, {apin, bpin})
    wr(T2W_OFF_CTRL_A, 8'h33);
    wr(T2W_OFF_CTRL_B, 8'h40);
    `CHK("force_pwm", 1'b0, bpin)
    wr(T2W_OFF_CTRL_A, 8'h10);
    wr(T2W_OFF_COUNT, t);
    wr(T2W_OFF_CTRL_B, 8'h01);
    p = bpin;
    wt(600, 1);
    `CHK("blocked", 1'b1, n > 200)
    `CHK("toggle", ~p, bpin)
    foreach (md[i]) for (int c = 2; c < 4; c++) begin
      wr(T2W_OFF_CTRL_B, 8'h00);
      wr(T2W_OFF_CMP_B, 8'h80);
      wr(T2W_OFF_COUNT, 8'h00);
      wr(T2W_OFF_CTRL_A, 8'(c * 16 + md[i]));
      wr(T2W_OFF_CTRL_B, 8'h01);
      wt(600, 1);
      `CHK("pwm_up", c & 1, bpin)
      wt(600, 1);
      `CHK("pwm_next", (c & 1) ^ (md[i] == 1), bpin)
    end
    foreach (md[i]) run(md[i], 1, 1);
    run(0, 1, 1);
    run(2, 1, 1);
    run(5, 1, 1);
    for (int c = 1; c < 8; c++) run(7, c, 1);
    xsel = 1;
    run(3, 1, 8);
    wrap_up();
  end
endmodule
`default_nettype wire
